// ---- shared/hefp_pkg.sv ----
// package for the hub end-of-frame timing point block
package hefp_pkg;
    localparam int CNT_W = 16;
    localparam int PORTS = 4;
    // cutoff offsets in bit times before end of frame
    localparam logic [15:0] HS_EARLY_BT = 16'h0230;
    localparam logic [15:0] HS_BABBLE_BT = 16'h0040;
    localparam logic [15:0] FS_EARLY_BT = 16'h0020;
    localparam logic [15:0] FS_BABBLE_BT = 16'h000A;
    // sof decode advance, bit times, within the allowed window
    localparam logic [15:0] HS_ADVANCE_BT = 16'h0040;
    localparam logic [15:0] FS_ADVANCE_BT = 16'h0010;
    // high speed counter ticks once per 16 bit times
    localparam int HS_DIV = 16;
    localparam int HS_DIV_SHIFT = 4;
    // upstream end-of-packet length in full speed bit times
    localparam logic [2:0] EOP_BT = 3'h4;
    // counter rollover limits
    localparam logic [15:0] HS_ROLL = 16'hFFFF;
    localparam logic [15:0] FS_ROLL = 16'h3FFF;

    typedef struct packed {
        logic early;
        logic babble;
    } hefp_cut_t;
endpackage : hefp_pkg

// ---- logic/hefp_top.sv ----
// end-of-frame early and babble cutoff point generator
//
// Functional notes
// - high speed early cutoff sits 560 bit times before microframe end.
// - high speed babble cutoff sits 64 bit times before microframe end.
// - full/low speed early cutoff sits 32 bit times before frame end.
// - full/low speed babble cutoff sits 10 bit times before frame end.
// - cutoff points are generated only while frame counter is locked.
// - at babble cutoff, ports still connected upstream are disabled as babblers.
// - full speed repeater sends upstream eop at early cutoff when connected.
// - full/low speed repeater may send eop at early cutoff when unconnected.
// - high speed repeater removes upstream connectivity at early cutoff.
// - high speed connection ends on idle plus empty elasticity buffer.
// - high speed repeater tolerates abrupt signalling end without eop.
// - high speed babble detection may use bit clock divided by 16.
// - upstream eop lasts four full speed bit times.
// - upstream eop completes before the parent hub's babble cutoff.
// - full speed placement holds across two lost sof packets.
// - bit times count down; last interval of frame is zero.
// - two consecutive sof packets lock the counter; reset leaves it unlocked.
// - cutoff points advanced for sof decode delay.
// - after resume, ports cannot gain connectivity until locked.
`timescale 1ns/100ps
module hefp_top (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic bit_tick,
    input wire logic hs_mode,
    input wire logic sof_seen,
    input wire logic resumed,
    input wire logic bus_idle,
    input wire logic ebuf_empty,
    input wire logic eop_on_idle,
    input wire logic [hefp_pkg::PORTS-1:0] port_conn_req,
    output logic locked_q,
    output hefp_pkg::hefp_cut_t cut_q,
    output logic [hefp_pkg::PORTS-1:0] port_conn_q,
    output logic [hefp_pkg::PORTS-1:0] babbler_q,
    output logic up_eop_q,
    output logic [hefp_pkg::CNT_W-1:0] frame_cnt_q
);
    localparam logic [3:0] HS_DIV_MAX = 4'(hefp_pkg::HS_DIV - 1);

    logic [3:0] div_q;
    logic cnt_tick;
    logic [15:0] cur_q;
    logic cur_rolled_q;
    logic [15:0] next_q;
    logic seen_one_q;
    logic [15:0] early_pt;
    logic [15:0] babble_pt;
    logic [2:0] eop_cnt_q;
    logic any_conn;
    logic hs_tear_q;

    // counter compare value for an offset; high speed works in /16 units
    function automatic logic [15:0] cut_value(input logic hs, input logic [15:0] bt,
                                              input logic [15:0] adv);
        logic [15:0] v;
        v = hs ? ((bt + adv) >> hefp_pkg::HS_DIV_SHIFT) : (bt + adv);
        return v;
    endfunction : cut_value

    assign early_pt = hs_mode ? cut_value(1'b1, hefp_pkg::HS_EARLY_BT, hefp_pkg::HS_ADVANCE_BT)
                              : cut_value(1'b0, hefp_pkg::FS_EARLY_BT, hefp_pkg::FS_ADVANCE_BT);
    assign babble_pt = hs_mode ? cut_value(1'b1, hefp_pkg::HS_BABBLE_BT, hefp_pkg::HS_ADVANCE_BT)
                               : cut_value(1'b0, hefp_pkg::FS_BABBLE_BT, hefp_pkg::FS_ADVANCE_BT);
    assign any_conn = |port_conn_q;

    // divider: both high speed offsets are multiples of 16, so no precision lost
    always_ff @(posedge core_clk)
    begin
        if (srst || !hs_mode)
            div_q <= 4'h0;
        else if (bit_tick)
            div_q <= (div_q == HS_DIV_MAX) ? 4'h0 : div_q + 4'h1;
    end
    assign cnt_tick = bit_tick && (!hs_mode || div_q == HS_DIV_MAX);

    // interval measurement between sof packets
    always_ff @(posedge core_clk)
    begin
        if (srst || resumed)
        begin
            cur_q <= 16'h0000;
            cur_rolled_q <= 1'b0;
            seen_one_q <= 1'b0;
            next_q <= 16'h0000;
            locked_q <= 1'b0;
        end
        else if (sof_seen)
        begin
            cur_q <= 16'h0000;
            cur_rolled_q <= 1'b0;
            seen_one_q <= 1'b1;
            if (seen_one_q && !cur_rolled_q)
            begin
                next_q <= cur_q;
                locked_q <= 1'b1;
            end
        end
        else if (cnt_tick)
        begin
            if (cur_q == (hs_mode ? hefp_pkg::HS_ROLL >> hefp_pkg::HS_DIV_SHIFT
                                  : hefp_pkg::FS_ROLL))
                cur_rolled_q <= 1'b1;
            else
                cur_q <= cur_q + 16'h0001;
        end
    end

    // down-counter: reaching zero marks end of frame; reloads keep running after missed sof
    always_ff @(posedge core_clk)
    begin
        if (srst || resumed)
            frame_cnt_q <= 16'h0000;
        else if (sof_seen && seen_one_q && !cur_rolled_q)
            frame_cnt_q <= cur_q;
        else if (cnt_tick)
            frame_cnt_q <= (frame_cnt_q == 16'h0000) ? next_q : frame_cnt_q - 16'h0001;
    end

    // one pulse per point per frame; compare only on the tick that entered the value
    always_ff @(posedge core_clk)
    begin
        if (srst || resumed)
            cut_q <= '0;
        else
        begin
            cut_q.early <= locked_q && cnt_tick && frame_cnt_q == early_pt + 16'h0001;
            cut_q.babble <= locked_q && cnt_tick && frame_cnt_q == babble_pt + 16'h0001;
        end
    end

    // per-port connectivity and babbler disable
    for (genvar p = 0; p < hefp_pkg::PORTS; p++)
    begin : g_port
        always_ff @(posedge core_clk)
        begin
            if (srst || resumed)
                babbler_q[p] <= 1'b0;
            else if (cut_q.babble && port_conn_q[p])
                babbler_q[p] <= 1'b1;
        end

        always_ff @(posedge core_clk)
        begin
            if (srst || resumed)
                port_conn_q[p] <= 1'b0;
            else if (!locked_q || babbler_q[p] || (cut_q.babble && port_conn_q[p]))
                port_conn_q[p] <= 1'b0;
            else if (hs_mode && (cut_q.early || hs_tear_q))
                port_conn_q[p] <= 1'b0;
            else if (!hs_mode && cut_q.early)
                port_conn_q[p] <= 1'b0;
            else if (!any_conn)
                port_conn_q[p] <= port_conn_req[p]
                                  && (port_conn_req & 4'((1 << p) - 1)) == 4'h0;
        end
    end

    // high speed teardown waits for idle and drained buffer, never for an eop pattern
    always_ff @(posedge core_clk)
    begin
        if (srst || resumed || !hs_mode)
            hs_tear_q <= 1'b0;
        else
            hs_tear_q <= any_conn && bus_idle && ebuf_empty;
    end

    // upstream eop lasts four full speed bit times, started at early cutoff
    always_ff @(posedge core_clk)
    begin
        if (srst || resumed || hs_mode)
        begin
            eop_cnt_q <= 3'h0;
            up_eop_q <= 1'b0;
        end
        else if (cut_q.early && (any_conn || eop_on_idle))
        begin
            eop_cnt_q <= hefp_pkg::EOP_BT;
            up_eop_q <= 1'b1;
        end
        else if (bit_tick && eop_cnt_q != 3'h0)
        begin
            eop_cnt_q <= eop_cnt_q - 3'h1;
            up_eop_q <= eop_cnt_q != 3'h1;
        end
    end
endmodule : hefp_top

// ---- bench/hefp_props.sv ----
// assertions for the end-of-frame cutoff block
`timescale 1ns/100ps
module hefp_props (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic hs_mode,
    input wire logic [3:0] port_conn_req,
    input wire logic locked_q,
    input wire hefp_pkg::hefp_cut_t cut_q,
    input wire logic [3:0] port_conn_q,
    input wire logic up_eop_q,
    input wire logic [15:0] frame_cnt_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // points include the sof decode advance; hs counts in 16 bit units
    property hit(logic hs, logic [15:0] v, logic c);
        locked_q && hs_mode == hs && frame_cnt_q == v && $changed(frame_cnt_q) |-> ##[0:2] c;
    endproperty
    a_hs_early_pt: assert property (hit(1'b1, 16'h0027, cut_q.early))
        else $error("hs early cutoff missing");
    a_hs_babble_pt: assert property (hit(1'b1, 16'h0008, cut_q.babble))
        else $error("hs babble cutoff missing");
    a_fs_early_pt: assert property (hit(1'b0, 16'h0030, cut_q.early))
        else $error("fs early cutoff missing");
    a_fs_babble_pt: assert property (hit(1'b0, 16'h001A, cut_q.babble))
        else $error("fs babble cutoff missing");
    a_unlocked_quiet: assert property (!locked_q && !$past(locked_q) |-> cut_q == 2'h0)
        else $error("cutoff while unlocked");
    a_babble_drop: assert property (cut_q.babble |-> ##[0:1] port_conn_q == 4'h0)
        else $error("port kept at babble cutoff");
    a_fs_eop_sent: assert property (cut_q.early && !hs_mode && |port_conn_q |-> ##1 up_eop_q)
        else $error("no eop at early cutoff");
    a_hs_teardown: assert property (cut_q.early && hs_mode |-> ##[0:1] port_conn_q == 4'h0)
        else $error("hs connectivity kept");
    c_babble: cover property (cut_q.babble);
    c_eop: cover property (up_eop_q);
    c_hs_cut: cover property (hs_mode && cut_q.early);
endmodule : hefp_props
bind hefp_top hefp_props u_props (.*);

// ---- bench/hefp_host.sv ----
// upstream host model: bit pacing and frame start pulses
`timescale 1ns/100ps
module hefp_host (
    input wire logic core_clk,
    input wire logic run,
    input wire logic [3:0] div,
    input wire logic [15:0] frame_bt,
    output logic bit_tick = 1'b0,
    output logic sof_seen = 1'b0
);
    logic [3:0] ph_q = 4'h0;
    logic [15:0] bt_q = 16'h0;
    // sends no packets, so nothing is pending at either cutoff
    // parses nothing upstream, so truncated hs traffic cannot upset it
    always @(negedge core_clk)
    begin
        bit_tick <= run && ph_q == 4'h0;
        sof_seen <= run && ph_q == 4'h0 && bt_q == 16'h0;
        ph_q <= (!run || ph_q == div - 4'h1) ? 4'h0 : ph_q + 4'h1;
        if (!run)
            bt_q <= 16'h0;
        else if (ph_q == 4'h0)
            bt_q <= (bt_q == frame_bt - 16'h1) ? 16'h0 : bt_q + 16'h1;
    end
endmodule : hefp_host

// ---- bench/testbench.sv ----
// self-checking bench for the end-of-frame cutoff block
`timescale 1ns/100ps
module testbench;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic hs_mode = 1'b0;
    logic resumed = 1'b0;
    logic eop_on_idle = 1'b0;
    logic run = 1'b0;
    logic [3:0] div = 4'h2;
    logic [15:0] frame_bt = 16'h0064;
    logic [3:0] req = 4'h0;
    logic bit_tick, sof_seen, locked_q, up_eop_q;
    logic [3:0] port_conn_q, babbler_q;
    logic [15:0] frame_cnt_q;
    hefp_pkg::hefp_cut_t cut_q;
    int bad_count = 0;
    int n_compared = 0;
    always #2.5 core_clk = ~core_clk;
    hefp_host HOST (.core_clk(core_clk), .run(run), .div(div), .frame_bt(frame_bt),
        .bit_tick(bit_tick), .sof_seen(sof_seen));
    hefp_top DUT (.core_clk(core_clk), .srst(srst), .bit_tick(bit_tick), .hs_mode(hs_mode),
        .sof_seen(sof_seen), .resumed(resumed), .bus_idle(1'b1), .ebuf_empty(1'b1),
        .eop_on_idle(eop_on_idle), .port_conn_req(req), .locked_q(locked_q), .cut_q(cut_q),
        .port_conn_q(port_conn_q), .babbler_q(babbler_q), .up_eop_q(up_eop_q),
        .frame_cnt_q(frame_cnt_q));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc
    // bounded wait on one cutoff pulse, bit 1 early, bit 0 babble
    task automatic wait_cut(input int b);
        repeat (3000) if (cut_q[b] !== 1'b1) @(negedge core_clk);
    endtask : wait_cut
    task automatic do_reset(input logic hs);
        srst = 1'b1;
        run = 1'b0;
        hs_mode = hs;
        cyc(5);
        srst = 1'b0;
        chk(16'({locked_q, cut_q, up_eop_q}), 16'h0);
    endtask : do_reset
    task automatic fs_frames;
        int n;
        logic prev;
        do_reset(1'b0);
        req = 4'h6;
        run = 1'b1;
        cyc(150);
        chk(16'({locked_q, port_conn_q}), 16'h0);
        cyc(60);
        chk(16'({locked_q, port_conn_q}), 16'h12);
        wait_cut(1);
        chk(16'(cut_q.early), 16'h1);
        chk(frame_cnt_q, 16'h0030);
        n = 0;
        prev = up_eop_q;
        // a bit is spent when a tick lands while the eop was already up
        repeat (20)
        begin
            cyc(1);
            n += int'(prev && bit_tick);
            prev = up_eop_q;
        end
        chk(16'(n), 16'h4);
        wait_cut(0);
        chk(frame_cnt_q, 16'h001A);
        cyc(2);
        chk(16'(babbler_q), 16'h2);
        req = 4'h0;
        eop_on_idle = 1'b1;
        wait_cut(1);
        cyc(3);
        chk(16'(up_eop_q), 16'h1);
        resumed = 1'b1;
        cyc(1);
        resumed = 1'b0;
        cyc(1);
        chk(16'({locked_q, babbler_q}), 16'h0);
    endtask : fs_frames
    task automatic hs_frames;
        do_reset(1'b1);
        div = 4'h1;
        frame_bt = 16'h0400;
        req = 4'h1;
        run = 1'b1;
        wait_cut(1);
        chk(16'(cut_q.early), 16'h1);
        chk(frame_cnt_q, 16'h0027);
        wait_cut(0);
        chk(16'(cut_q.babble), 16'h1);
        chk(frame_cnt_q, 16'h0008);
    endtask : hs_frames
    task automatic tally_and_finish;
        $display("compared=%0d mismatches=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        fs_frames;
        hs_frames;
        tally_and_finish;
    end
    initial
    begin
        #100000;
        bad_count++;
        tally_and_finish;
    end
endmodule : testbench
